// *** hw/result_regs_cfg.svh ***
// Purpose: Constants for the result and integrity register bank
// Assumes: Included by bare name from design files
// Notes: Offsets are register addresses on the serial interface
`ifndef RESULT_REGS_CFG_SVH
`define RESULT_REGS_CFG_SVH
`define ADDR_IFCFG 8'h02
`define ADDR_XOR_SUM 8'h03
`define ADDR_RESULT 8'h04
`define ADDR_STATUS 8'h00
`define IFCFG_SHORT_WORD 0
`define IFCFG_RSVD1 1
`define IFCFG_CSUM_LO 2
`define IFCFG_CSUM_HI 3
`define IFCFG_RSVD4 4
`define IFCFG_CHECK_EN 5
`define IFCFG_APPEND_STAT 6
`define IFCFG_RESET 16'h0000
`define XOR_SUM_RESET 24'h000000
`define RESULT_RESET 24'h000000
`define STATUS_RDY_N_BIT 7
`define STATUS_REG_ERR_BIT 4
`endif

// *** hw/result_regs_pkg.sv ***
// Purpose: Types for the result and integrity register bank
// Assumes: Nothing imported
// Notes: Checksum mode encodings
package result_regs_pkg;
    typedef enum logic [1:0] {
        CSUM_OFF = 2'b00,
        CSUM_XOR_RD = 2'b01,
        CSUM_CRC_RW = 2'b10,
        CSUM_RSVD = 2'b11
    } csum_mode_t;
    typedef enum logic [1:0] {
        LEN_16 = 2'b00,
        LEN_24 = 2'b01,
        LEN_32 = 2'b10,
        LEN_40 = 2'b11
    } read_len_t;
endpackage

// *** hw/xor_fold.sv ***
// Purpose: XOR fold of checked user registers into a 24-bit sum
// Assumes: Registers packed as 24-bit lanes
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
module xor_fold #(
    parameter int NUM_REGS = 4
) (
    // Checked registers
    input wire logic [NUM_REGS*24-1:0] regs_i,
    // Folded sum
    output logic [23:0] sum_o
);
    logic [23:0] acc [0:NUM_REGS];
    assign acc[0] = 24'h000000;
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_fold
            assign acc[g+1] = acc[g] ^ regs_i[g*24 +: 24];
        end
    endgenerate
    assign sum_o = acc[NUM_REGS];
endmodule // xor_fold
`default_nettype wire

// *** hw/result_regs.sv ***
// Purpose: Interface config fields, integrity XOR sum and conversion result registers
// Assumes: Serial engine decodes commands; this bank answers register accesses
// Notes: Ready flag is active low, shared by status bit and pin
`timescale 1ns/1ps
`default_nettype none
`include "result_regs_cfg.svh"
module result_regs #(
    parameter int NUM_CHECKED = 4
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // Register access from serial engine
    input wire logic wr_i,
    input wire logic rd_start_i,
    input wire logic rd_end_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    // Converter datapath
    input wire logic conv_valid_i,
    input wire logic [23:0] conv_raw_i,
    input wire logic polarity_select_i,
    input wire logic [NUM_CHECKED*24-1:0] checked_regs_i,
    input wire logic [7:0] status_in_i,
    // Read answer and controls
    output logic [39:0] rdata_o,
    output logic [5:0] rd_bits_o,
    output logic [1:0] csum_mode_o,
    output logic crc_on_wr_o,
    output logic csum_extra_byte_o,
    output logic rdy_n_o,
    output logic reg_error_o
);
    logic [15:0] ifcfg_reg, ifcfg_next;
    logic [23:0] result_reg, result_next;
    logic result_short_reg, result_short_next;
    logic rdy_n_reg, rdy_n_next;
    logic lock_reg, lock_next;
    logic [23:0] snap_reg, snap_next;
    logic err_reg, err_next;
    logic [39:0] rdata_reg, rdata_next;
    logic [5:0] rd_bits_reg, rd_bits_next;
    logic [1:0] mode_reg, mode_next;
    logic crcw_reg, crcw_next;
    logic extra_reg, extra_next;
    logic [23:0] xor_now;
    logic check_en;
    logic [23:0] coded;
    logic [7:0] status_full;

    xor_fold #(.NUM_REGS(NUM_CHECKED)) u_fold (
        .regs_i(checked_regs_i),
        .sum_o(xor_now)
    );

    assign check_en = ifcfg_reg[`IFCFG_CHECK_EN];

    function automatic logic [5:0] read_bits(input logic short_w, input logic app);
        read_bits = (short_w ? 6'h10 : 6'h18) + (app ? 6'h08 : 6'h00);
    endfunction

    // Result read command as the serial engine presents it
    function automatic logic is_result_read(input logic rd, input logic [7:0] a);
        is_result_read = rd && (a == `ADDR_RESULT);
    endfunction

    always_comb begin
        ifcfg_next = ifcfg_reg;
        result_next = result_reg;
        result_short_next = result_short_reg;
        rdy_n_next = rdy_n_reg;
        lock_next = lock_reg;
        snap_next = snap_reg;
        err_next = err_reg;
        rdata_next = rdata_reg;
        rd_bits_next = rd_bits_reg;
        if (wr_i && addr_i == `ADDR_IFCFG) begin
            ifcfg_next = wdata_i;
            ifcfg_next[`IFCFG_RSVD1] = 1'b0;
            ifcfg_next[`IFCFG_RSVD4] = 1'b0;
            if (!wdata_i[`IFCFG_CHECK_EN]) begin
                err_next = 1'b0;
            end else if (!check_en) begin
                // Reference taken on the enable edge only; rewriting 1 keeps it
                snap_next = xor_now;
            end
        end
        // Set wins over a same-cycle clear; re-arm so only a new change sets again
        if (check_en && xor_now != snap_reg) begin
            err_next = 1'b1;
            snap_next = xor_now;
        end
        if (is_result_read(rd_start_i, addr_i)) begin
            lock_next = 1'b1;
            rdy_n_next = 1'b1;
        end
        if (rd_end_i) begin
            // Loads reopen only once the read has fully shifted out
            lock_next = 1'b0;
        end
        if (conv_valid_i && !lock_reg && !is_result_read(rd_start_i, addr_i)) begin
            // Width latched at load time, so older results keep theirs
            result_short_next = ifcfg_reg[`IFCFG_SHORT_WORD];
            result_next = ifcfg_reg[`IFCFG_SHORT_WORD] ? {8'h00, coded[23:8]} : coded;
            rdy_n_next = 1'b0;
        end
        if (rd_start_i) begin
            unique case (addr_i)
                `ADDR_IFCFG: begin
                    rdata_next = {24'h000000, ifcfg_reg};
                    rd_bits_next = 6'h10;
                end
                `ADDR_XOR_SUM: begin
                    rdata_next = {16'h0000, (check_en ? xor_now : `XOR_SUM_RESET)};
                    rd_bits_next = 6'h18;
                end
                `ADDR_RESULT: begin
                    rd_bits_next = read_bits(result_short_reg,
                        ifcfg_reg[`IFCFG_APPEND_STAT]);
                    if (ifcfg_reg[`IFCFG_APPEND_STAT]) begin
                        rdata_next = result_short_reg
                            ? {16'h0000, result_reg[15:0], status_full}
                            : {8'h00, result_reg, status_full};
                    end else begin
                        rdata_next = {16'h0000, result_reg};
                    end
                end
                `ADDR_STATUS: begin
                    rdata_next = {32'h00000000, status_full};
                    rd_bits_next = 6'h08;
                end
                default: begin
                    rdata_next = 40'h0000000000;
                    rd_bits_next = 6'h08;
                end
            endcase
        end
    end

    // Status byte carries the live ready and integrity flags
    always_comb begin
        // Offset binary flips the sign bit; unipolar is straight
        coded = polarity_select_i ? conv_raw_i : (conv_raw_i ^ 24'h800000);
        status_full = status_in_i;
        status_full[`STATUS_RDY_N_BIT] = rdy_n_reg;
        status_full[`STATUS_REG_ERR_BIT] = err_reg;
    end

    always_comb begin
        mode_next = ifcfg_reg[`IFCFG_CSUM_HI:`IFCFG_CSUM_LO];
        // Modes 01 and 10 protect writes with CRC; reserved 11 leaves it off
        unique case (mode_next)
            result_regs_pkg::CSUM_OFF: crcw_next = 1'b0;
            result_regs_pkg::CSUM_XOR_RD: crcw_next = 1'b1;
            result_regs_pkg::CSUM_CRC_RW: crcw_next = 1'b1;
            result_regs_pkg::CSUM_RSVD: crcw_next = 1'b0;
        endcase
        extra_next = (mode_next != result_regs_pkg::CSUM_OFF);
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ifcfg_reg <= `IFCFG_RESET;
            result_reg <= `RESULT_RESET;
            result_short_reg <= 1'b0;
            rdy_n_reg <= 1'b1;
            lock_reg <= 1'b0;
            snap_reg <= `XOR_SUM_RESET;
            err_reg <= 1'b0;
            rdata_reg <= 40'h0000000000;
            rd_bits_reg <= 6'h18;
        end else if (clk_en_i) begin
            ifcfg_reg <= ifcfg_next;
            result_reg <= result_next;
            result_short_reg <= result_short_next;
            rdy_n_reg <= rdy_n_next;
            lock_reg <= lock_next;
            snap_reg <= snap_next;
            err_reg <= err_next;
            rdata_reg <= rdata_next;
            rd_bits_reg <= rd_bits_next;
        end
    end

    // Checksum controls trail the config register by one cycle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_reg <= 2'h0;
            crcw_reg <= 1'b0;
            extra_reg <= 1'b0;
        end else if (clk_en_i) begin
            mode_reg <= mode_next;
            crcw_reg <= crcw_next;
            extra_reg <= extra_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign rd_bits_o = rd_bits_reg;
    assign csum_mode_o = mode_reg;
    assign crc_on_wr_o = crcw_reg;
    assign csum_extra_byte_o = extra_reg;
    assign rdy_n_o = rdy_n_reg;
    assign reg_error_o = err_reg;
endmodule // result_regs
`default_nettype wire

// *** sim/result_regs_checker.sv ***
// Purpose: Port checks for result_regs
// Assumes: One clock, config shadowed from writes
// Notes: Bound by port names
`timescale 1ns/1ps
`default_nettype none
module result_regs_checker (
    // Clock, reset, access
    input wire logic clk_i, reset_n_i, clk_en_i, wr_i, rd_start_i, rd_end_i, conv_valid_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    // Outputs watched
    input wire logic [39:0] rdata_o,
    input wire logic [5:0] rd_bits_o,
    input wire logic [1:0] csum_mode_o,
    input wire logic crc_on_wr_o, csum_extra_byte_o, rdy_n_o, reg_error_o
);
    logic en_reg, en_next, busy_reg, busy_next, rd_res;
    assign rd_res = clk_en_i && rd_start_i && addr_i == 8'h04;
    always_comb begin
        en_next = en_reg;
        busy_next = busy_reg;
        if (clk_en_i && wr_i && addr_i == 8'h02) en_next = wdata_i[5];
        if (clk_en_i && rd_end_i) busy_next = 1'b0;
        if (clk_en_i && rd_start_i) busy_next = addr_i == 8'h04;
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            en_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            en_reg <= en_next;
            busy_reg <= busy_next;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    rdy_raise_a: assert property (rd_res |=> rdy_n_o)
        else $error("ready flag not raised by result read");
    load_lock_a: assert property (busy_reg && !rd_end_i && !rd_start_i
        |=> rdy_n_o && $stable(rdata_o))
        else $error("result changed during read");
    res_width_a: assert property (rd_res |=> rd_bits_o inside {6'h10, 6'h18, 6'h20})
        else $error("bad result read length");
    sum_zero_a: assert property (rd_start_i && clk_en_i && addr_i == 8'h03 && !en_reg
        |=> rdata_o == 40'h0)
        else $error("sum not zero while check off");
    csum_off_a: assert property (csum_mode_o == 2'b00 |-> !crc_on_wr_o && !csum_extra_byte_o)
        else $error("checksum active in off mode");
    csum_xor_a: assert property (csum_mode_o == 2'b01 |-> crc_on_wr_o && csum_extra_byte_o)
        else $error("xor mode controls wrong");
    csum_crc_a: assert property (csum_mode_o == 2'b10 |-> crc_on_wr_o && csum_extra_byte_o)
        else $error("crc mode controls wrong");
    err_clear_a: assert property (clk_en_i && wr_i && addr_i == 8'h02 && !wdata_i[5]
        |-> ##[1:3] !reg_error_o)
        else $error("integrity error not cleared");
    cover property (rd_res);
    cover property (busy_reg && conv_valid_i);
    cover property ($rose(reg_error_o));
endmodule // result_regs_checker
bind result_regs result_regs_checker u_result_regs_checker (.*);
`default_nettype wire

// *** sim/host_model.sv ***
// Purpose: Host side of the register interface
// Assumes: Bench calls its tasks
// Notes: Address inverted when idle, not left at last value
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input wire logic clk_i,
    // Register access
    output logic wr_i, rd_start_i, rd_end_i,
    output logic [7:0] addr_i,
    output logic [15:0] wdata_i
);
    initial begin
        {wr_i, rd_start_i, rd_end_i} = 3'h0;
        addr_i = 8'hff;
        wdata_i = 16'h0000;
    end
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d & 16'hfffd;
        @(posedge clk_i);
        wr_i <= 1'b0;
        addr_i <= ~a;
        wdata_i <= ~d;
    endtask
    task automatic rd_begin(input logic [7:0] a);
        @(posedge clk_i);
        rd_start_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_start_i <= 1'b0;
        addr_i <= ~a;
    endtask
    task automatic rd_finish;
        @(posedge clk_i);
        rd_end_i <= 1'b1;
        @(posedge clk_i);
        rd_end_i <= 1'b0;
    endtask
endmodule // host_model
`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for result_regs
// Assumes: 40 MHz clock, clock enable held high
// Notes: Expectations from offset binary and field layout
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int NUM_CHECKED = 2;
    logic clk_i = 1'b0, reset_n_i = 1'b0, clk_en_i = 1'b1, conv_valid_i = 1'b0;
    logic polarity_select_i = 1'b0, wr_i, rd_start_i, rd_end_i;
    logic [7:0] addr_i, status_in_i = 8'h00;
    logic [15:0] wdata_i;
    logic [23:0] conv_raw_i = 24'h000000;
    logic [NUM_CHECKED*24-1:0] checked_regs_i = {NUM_CHECKED{24'h000000}};
    logic [39:0] rdata_o;
    logic [5:0] rd_bits_o;
    logic [1:0] csum_mode_o;
    logic crc_on_wr_o, csum_extra_byte_o, rdy_n_o, reg_error_o;
    int fails = 0, samples_checked = 0;
    always #12.5 clk_i = ~clk_i;
    result_regs #(.NUM_CHECKED(NUM_CHECKED)) u_result_regs (.*);
    host_model u_host_model (.*);
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic convert(input logic [23:0] raw);
        @(posedge clk_i);
        conv_raw_i <= raw;
        conv_valid_i <= 1'b1;
        @(posedge clk_i);
        conv_valid_i <= 1'b0;
    endtask
    task automatic t_csum;
        for (int m = 0; m < 3; m++) begin
            u_host_model.write_reg(8'h02, {12'h000, m[1:0], 2'h0});
            repeat (3) @(posedge clk_i);
            #1 check(40'({csum_mode_o, crc_on_wr_o, csum_extra_byte_o}),
                40'({m[1:0], m != 0, m != 0}));
        end
    endtask
    task automatic t_result;
        convert(24'h123456);
        @(posedge clk_i);
        #1 check(40'(rdy_n_o), 40'h0);
        repeat (2) begin
            u_host_model.rd_begin(8'h04);
            #1 check(rdata_o, 40'h923456);
            check(40'({rd_bits_o, rdy_n_o}), 40'({6'h18, 1'b1}));
            convert(24'h00ffff);
            u_host_model.rd_finish;
        end
        u_host_model.write_reg(8'h02, 16'h0043);
        u_host_model.rd_begin(8'h02);
        #1 check(rdata_o, 40'h0000000041);
        u_host_model.rd_finish;
        // Held result keeps 24 bits; status byte shows ready high
        u_host_model.rd_begin(8'h04);
        #1 check(rdata_o, 40'h0092345680);
        check(40'(rd_bits_o), 40'h20);
        u_host_model.rd_finish;
        convert(24'h9abcde);
        u_host_model.rd_begin(8'h04);
        #1 check(rdata_o, 40'h00001abc00);
        check(40'(rd_bits_o), 40'h18);
        u_host_model.rd_finish;
        polarity_select_i <= 1'b1;
        convert(24'h9abcde);
        u_host_model.rd_begin(8'h04);
        #1 check(rdata_o, 40'h00009abc00);
        u_host_model.rd_finish;
        polarity_select_i <= 1'b0;
    endtask
    task automatic t_xor;
        checked_regs_i <= {24'h0f0f0f, 24'h111111};
        u_host_model.write_reg(8'h02, 16'h0020);
        u_host_model.rd_begin(8'h03);
        #1 check(rdata_o, 40'h1e1e1e);
        u_host_model.rd_finish;
        checked_regs_i <= {24'h0f0f0f, 24'h111110};
        repeat (3) @(posedge clk_i);
        #1 check(40'(reg_error_o), 40'h1);
        u_host_model.write_reg(8'h02, 16'h0000);
        u_host_model.rd_begin(8'h03);
        #1 check(40'({rdata_o[23:0], reg_error_o}), 40'h0);
        u_host_model.rd_finish;
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        #1 check(40'({rdata_o, rdy_n_o, reg_error_o}), 40'h2);
        t_csum;
        t_result;
        t_xor;
        end_of_test;
    end
    initial begin
        #100000;
        fails++;
        end_of_test;
    end
endmodule // tb_top
`default_nettype wire
